/* File: cvs_cfg.svh */
// timing counts for the composite video sync generator
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH
`define CVS_W 11
`define CVS_LINE_525 11'd1716
`define CVS_LINE_625 11'd1728
`define CVS_HALF_525 11'd858
`define CVS_HALF_625 11'd864
`define CVS_HSYNC_LEN 11'd128
`define CVS_RAMP_STEPS 3'h4
`define CVS_BURST_AT_525 11'd144
`define CVS_BURST_AT_625 11'd153
`define CVS_BURST_LEN_525 11'd63
`define CVS_BURST_LEN_625 11'd66
`define CVS_ACT_AT_525 11'd255
`define CVS_ACT_AT_625 11'd279
`define CVS_ACT_LEN_525 11'd1423
`define CVS_ACT_LEN_625 11'd1413
`define CVS_FRONT_525 11'd36
`define CVS_FRONT_625 11'd39
`define CVS_LEAD_OS_525 11'd9
`define CVS_LEAD_OS_625 11'd14
`define CVS_TRAIL_OS_525 11'd8
`define CVS_TRAIL_OS_625 11'd13
`define CVS_EQ_LEN 11'd64
`define CVS_EQ_GAP_525 11'd38
`define CVS_EQ_GAP_625 11'd41
`define CVS_BROAD_525 11'd730
`define CVS_BROAD_625 11'd736
`define CVS_BROAD_GAP 11'd128
`define CVS_FIELD_HALVES_525 10'd525
`define CVS_FIELD_HALVES_625 10'd625
`endif

/* File: cvs_pkg.sv */
// types for the composite video sync generator
package cvs_pkg;
  typedef enum logic [1:0] {CVS_NORMAL, CVS_EQUAL, CVS_BROAD} cvs_mode_t;
endpackage

/* File: cvs_ramp.sv */
// sync edge ramp, one step per enabled cycle
`timescale 1ns/100ps
`default_nettype none
`include "cvs_cfg.svh"
module cvs_ramp import cvs_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic target,
  output logic [2:0] level
);
  logic [2:0] level_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 3'h0;
    end else if (clk_en) begin
      if (target && level_q < `CVS_RAMP_STEPS) begin
        level_q <= level_q + 3'h1;
      end else if (!target && level_q != 3'h0) begin
        level_q <= level_q - 3'h1;
      end
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

/* File: cvs_timing.sv */
// composite video horizontal and vertical sync timing generator
`timescale 1ns/100ps
`default_nettype none
`include "cvs_cfg.svh"
module cvs_timing import cvs_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic std_625_pin,
  input wire logic [1:0] line_mode_pin,
  output logic [2:0] sync_level,
  output logic sync_on,
  output logic burst_win,
  output logic active_video,
  output logic leading_overscan_margin,
  output logic trailing_overscan_margin,
  output logic front_blank,
  output logic period_start,
  output logic field_start
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [`CVS_W-1:0] pick(input logic s, input logic [`CVS_W-1:0] a,
                                              input logic [`CVS_W-1:0] b);
    return s ? b : a;
  endfunction

  function automatic logic in_win(input logic [`CVS_W-1:0] h, input logic [`CVS_W-1:0] lo,
                                  input logic [`CVS_W-1:0] len);
    logic [`CVS_W:0] hi;
    hi = {1'b0, lo} + {1'b0, len};
    return ({1'b0, h} >= {1'b0, lo}) && ({1'b0, h} < hi);
  endfunction

  function automatic cvs_mode_t decode_mode(input logic [1:0] m);
    cvs_mode_t r;
    case (m)
      2'h1: r = CVS_EQUAL;
      2'h2: r = CVS_BROAD;
      default: r = CVS_NORMAL;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic std_m_q, std_s_q;
  logic [1:0] mode_m_q, mode_s_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      std_m_q <= 1'b0;
      std_s_q <= 1'b0;
      mode_m_q <= 2'h0;
      mode_s_q <= 2'h0;
    end else if (clk_en) begin
      std_m_q <= std_625_pin;
      std_s_q <= std_m_q;
      mode_m_q <= line_mode_pin;
      mode_s_q <= mode_m_q;
    end
  end

  // ------------------------------------------------------------
  // period counter
  // ------------------------------------------------------------
  logic std_q;
  cvs_mode_t mode_q;
  logic [`CVS_W-1:0] hcnt_q;
  logic [`CVS_W-1:0] period;
  logic [`CVS_W-1:0] period_m1;
  logic wrap;

  always_comb begin
    case (mode_q)
      CVS_NORMAL: period = pick(std_q, `CVS_LINE_525, `CVS_LINE_625);
      CVS_EQUAL: period = pick(std_q, `CVS_HALF_525, `CVS_HALF_625);
      CVS_BROAD: period = pick(std_q, `CVS_HALF_525, `CVS_HALF_625);
      default: period = pick(std_q, `CVS_LINE_525, `CVS_LINE_625);
    endcase
  end

  assign period_m1 = period - 11'd1;
  assign wrap = (hcnt_q == period_m1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= '0;
    end else if (clk_en) begin
      hcnt_q <= wrap ? '0 : hcnt_q + 11'd1;
    end
  end

  // standard and line kind change only at a period boundary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      std_q <= 1'b0;
      mode_q <= CVS_NORMAL;
    end else if (clk_en && wrap) begin
      std_q <= std_s_q;
      mode_q <= decode_mode(mode_s_q);
    end
  end

  // ------------------------------------------------------------
  // field counter in half-lines
  // ------------------------------------------------------------
  logic [9:0] hl_q;
  logic [9:0] halves;
  logic [9:0] hl_next;
  logic field_start_q;

  assign halves = std_q ? `CVS_FIELD_HALVES_625 : `CVS_FIELD_HALVES_525;
  assign hl_next = hl_q + ((mode_q == CVS_NORMAL) ? 10'd2 : 10'd1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hl_q <= 10'h0;
      field_start_q <= 1'b0;
    end else if (clk_en) begin
      field_start_q <= 1'b0;
      if (wrap) begin
        if (hl_next >= halves) begin
          hl_q <= hl_next - halves;
          field_start_q <= 1'b1;
        end else begin
          hl_q <= hl_next;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // window positions
  // ------------------------------------------------------------
  logic [`CVS_W-1:0] burst_at, burst_len, act_at, act_len, act_end, front_len;
  logic [`CVS_W-1:0] lead_len, trail_len, eq_gap, broad_len;

  assign burst_at = pick(std_q, `CVS_BURST_AT_525, `CVS_BURST_AT_625);
  assign burst_len = pick(std_q, `CVS_BURST_LEN_525, `CVS_BURST_LEN_625);
  assign act_at = pick(std_q, `CVS_ACT_AT_525, `CVS_ACT_AT_625);
  assign act_len = pick(std_q, `CVS_ACT_LEN_525, `CVS_ACT_LEN_625);
  assign act_end = act_at + act_len;
  assign front_len = pick(std_q, `CVS_FRONT_525, `CVS_FRONT_625);
  assign lead_len = pick(std_q, `CVS_LEAD_OS_525, `CVS_LEAD_OS_625);
  assign trail_len = pick(std_q, `CVS_TRAIL_OS_525, `CVS_TRAIL_OS_625);
  assign eq_gap = pick(std_q, `CVS_EQ_GAP_525, `CVS_EQ_GAP_625);
  assign broad_len = pick(std_q, `CVS_BROAD_525, `CVS_BROAD_625);

  // ------------------------------------------------------------
  // sync target and ramp
  // ------------------------------------------------------------
  logic sync_tgt;

  always_comb begin
    case (mode_q)
      CVS_NORMAL: sync_tgt = in_win(hcnt_q, 11'd0, `CVS_HSYNC_LEN);
      CVS_EQUAL: sync_tgt = in_win(hcnt_q, eq_gap, `CVS_EQ_LEN);
      CVS_BROAD: sync_tgt = in_win(hcnt_q, 11'd0, broad_len);
      default: sync_tgt = 1'b0;
    endcase
  end

  cvs_ramp u_ramp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .target(sync_tgt),
    .level(sync_level)
  );

  // ------------------------------------------------------------
  // line windows
  // ------------------------------------------------------------
  logic norm;
  logic sync_on_q, burst_q, act_q, lead_q, trail_q, front_q, period_start_q;

  assign norm = (mode_q == CVS_NORMAL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_on_q <= 1'b0;
      period_start_q <= 1'b0;
    end else if (clk_en) begin
      sync_on_q <= sync_tgt;
      period_start_q <= (hcnt_q == 11'd0);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= 1'b0;
      act_q <= 1'b0;
      front_q <= 1'b0;
    end else if (clk_en) begin
      burst_q <= norm && in_win(hcnt_q, burst_at, burst_len);
      act_q <= norm && in_win(hcnt_q, act_at, act_len);
      front_q <= norm && in_win(hcnt_q, act_end, front_len);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_q <= 1'b0;
      trail_q <= 1'b0;
    end else if (clk_en) begin
      lead_q <= norm && in_win(hcnt_q, act_at, lead_len);
      trail_q <= norm && in_win(hcnt_q, act_end - trail_len, trail_len);
    end
  end

  assign sync_on = sync_on_q;
  assign burst_win = burst_q;
  assign active_video = act_q;
  assign leading_overscan_margin = lead_q;
  assign trailing_overscan_margin = trail_q;
  assign front_blank = front_q;
  assign period_start = period_start_q;
  assign field_start = field_start_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_line_len;
    (clk_en && wrap && norm) |-> (hcnt_q == (std_q ? 11'd1727 : 11'd1715));
  endproperty
  a_line_len: assert property (p_line_len) else $error("line length wrong");

  property p_restart;
    (clk_en && wrap) |=> (hcnt_q == 11'd0);
  endproperty
  a_restart: assert property (p_restart) else $error("counter did not restart");

  property p_hsync;
    (clk_en && norm && hcnt_q < 11'd128) |=> sync_on;
  endproperty
  a_hsync: assert property (p_hsync) else $error("hsync not held");

  sequence s_rise;
    (sync_level == 3'h0 && sync_tgt && clk_en) ##1 (sync_tgt && clk_en) [*3];
  endsequence
  property p_ramp;
    s_rise |=> (sync_level == 3'h4);
  endproperty
  a_ramp: assert property (p_ramp) else $error("sync ramp not 4 cycles");

  property p_burst;
    (clk_en && norm && hcnt_q == (std_q ? 11'd153 : 11'd144)) |=> burst_win ##1 (!clk_en || burst_win);
  endproperty
  a_burst: assert property (p_burst) else $error("burst start wrong");

  property p_burst_end;
    (clk_en && norm && hcnt_q == (std_q ? 11'd219 : 11'd207)) |=> !burst_win && $past(burst_win);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst length wrong");

  property p_active;
    (clk_en && norm && hcnt_q == (std_q ? 11'd279 : 11'd255)) |=> active_video && leading_overscan_margin;
  endproperty
  a_active: assert property (p_active) else $error("active start wrong");

  property p_active_end;
    (clk_en && norm && hcnt_q == (std_q ? 11'd1691 : 11'd1677)) |=> active_video && trailing_overscan_margin;
  endproperty
  a_active_end: assert property (p_active_end) else $error("active end wrong");

  property p_front;
    (clk_en && norm && hcnt_q == (std_q ? 11'd1692 : 11'd1678)) |=> front_blank && !active_video;
  endproperty
  a_front: assert property (p_front) else $error("front blank wrong");

  property p_equal;
    (clk_en && mode_q == CVS_EQUAL && hcnt_q == (std_q ? 11'd41 : 11'd38)) |=> sync_on;
  endproperty
  a_equal: assert property (p_equal) else $error("equalizing pulse misplaced");

  property p_broad_gap;
    (clk_en && mode_q == CVS_BROAD && hcnt_q == (std_q ? 11'd736 : 11'd730)) |=> !sync_on;
  endproperty
  a_broad_gap: assert property (p_broad_gap) else $error("broad pulse width wrong");
endmodule
`default_nettype wire

/* File: cvs_timing_bench.sv */
// self-checking bench for the composite video sync timing generator
`timescale 1ns/100ps
`default_nettype none
module cvs_timing_bench import cvs_pkg::*; ;
  typedef struct {logic s; logic [1:0] m; int plen; int f[6]; int n[6];} cvs_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic std_625_pin = 1'b0;
  logic [1:0] line_mode_pin = 2'h0;
  logic [2:0] sync_level;
  logic sync_on, burst_win, active_video, leading_overscan_margin, trailing_overscan_margin;
  logic front_blank, period_start, field_start;
  logic [5:0] mon_v;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n_field = 0;
  time t_rel;
  int pos = 0;
  int lvl4 = 0;
  int ramp = 0;
  int first_q[6];
  int cnt_q[6];
  int d_plen, d_lvl4, d_ramp;
  int d_first[6];
  int d_cnt[6];
  event per_done;
  // ----------------------------------------
  // ordinary cases: standard, period kind, expected windows
  // ----------------------------------------
  cvs_row_t rows[7] = '{
    '{1'b0, 2'h0, 1716, '{0, 144, 255, 255, 1670, 1678}, '{128, 63, 1423, 9, 8, 36}},
    '{1'b1, 2'h0, 1728, '{0, 153, 279, 279, 1679, 1692}, '{128, 66, 1413, 14, 13, 36}},
    '{1'b0, 2'h1, 858, '{38, -1, -1, -1, -1, -1}, '{64, 0, 0, 0, 0, 0}},
    '{1'b1, 2'h1, 864, '{41, -1, -1, -1, -1, -1}, '{64, 0, 0, 0, 0, 0}},
    '{1'b0, 2'h2, 858, '{0, -1, -1, -1, -1, -1}, '{730, 0, 0, 0, 0, 0}},
    '{1'b1, 2'h2, 864, '{0, -1, -1, -1, -1, -1}, '{736, 0, 0, 0, 0, 0}},
    '{1'b0, 2'h3, 1716, '{0, 144, 255, 255, 1670, 1678}, '{128, 63, 1423, 9, 8, 36}}};

  always #4 sys_clk = ~sys_clk;

  cvs_timing u_cvs_timing (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .std_625_pin(std_625_pin),
    .line_mode_pin(line_mode_pin),
    .sync_level(sync_level),
    .sync_on(sync_on),
    .burst_win(burst_win),
    .active_video(active_video),
    .leading_overscan_margin(leading_overscan_margin),
    .trailing_overscan_margin(trailing_overscan_margin),
    .front_blank(front_blank),
    .period_start(period_start),
    .field_start(field_start)
  );

  assign mon_v = {front_blank, trailing_overscan_margin, leading_overscan_margin, active_video, burst_win, sync_on};

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input int got, input int exp, input string m);
    check_count++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, m, got, exp);
    end
  endtask

  // ----------------------------------------
  // period monitor, sampled on settled outputs
  // ----------------------------------------
  always @(negedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_fail++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end

  always @(negedge sys_clk) begin
    if (field_start === 1'b1) n_field++;
    if (period_start === 1'b1) begin
      d_plen = pos + 1;
      d_first = first_q;
      d_cnt = cnt_q;
      d_lvl4 = lvl4;
      d_ramp = ramp;
      pos = 0;
      lvl4 = 0;
      ramp = 0;
      for (int i = 0; i < 6; i++) begin
        first_q[i] = -1;
        cnt_q[i] = 0;
      end
      -> per_done;
    end else begin
      pos++;
    end
    for (int i = 0; i < 6; i++) begin
      if (mon_v[i] === 1'b1) begin
        if (first_q[i] < 0) first_q[i] = pos;
        cnt_q[i]++;
      end
    end
    if (sync_level === 3'h4) lvl4++;
    else if (sync_level !== 3'h0) ramp++;
  end

  task automatic run_row(input logic s, input logic [1:0] m);
    @(per_done);
    std_625_pin = s;
    line_mode_pin = m;
    @(per_done);
    @(per_done);
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    @(per_done);
    for (int r = 0; r < 7; r++) begin
      run_row(rows[r].s, rows[r].m);
      chk(d_plen, rows[r].plen, "period length");
      for (int i = 0; i < 6; i++) begin
        chk(d_first[i], rows[r].f[i], "window start");
        if (rows[r].n[i] >= 0) chk(d_cnt[i], rows[r].n[i], "window length");
      end
      chk(d_ramp, 6, "ramp cycles");
      chk(d_lvl4, rows[r].n[0] - 3, "sync tip cycles");
      $display("row %0d done", r);
    end
    // ----------------------------------------
    // standard change mid-period waits for the wrap
    // ----------------------------------------
    @(per_done);
    repeat (100) @(negedge sys_clk);
    std_625_pin = 1'b1;
    @(per_done);
    chk(d_plen, 1716, "changed mid-period");
    @(per_done);
    chk(d_plen, 1728, "adopted at wrap");
    $display("mid-period change test done");
    // ----------------------------------------
    // clock enable low freezes the count
    // ----------------------------------------
    repeat (50) @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    clk_en = 1'b1;
    @(per_done);
    chk(d_plen, 1748, "frozen period");
    chk(d_cnt[0], 148, "frozen sync");
    $display("freeze test done");
    // ----------------------------------------
    // reset in mid-run returns to the 525 set
    // ----------------------------------------
    repeat (300) @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(int'({sync_level, mon_v, period_start, field_start} === 11'h000), 1, "outputs in reset");
    rst_n = 1'b1;
    t_rel = $time;
    @(per_done);
    chk(int'($time - t_rel), 8, "period start after release");
    chk(int'(sync_on === 1'b1 && sync_level === 3'h1), 1, "first edge after release");
    @(negedge sys_clk);
    chk(int'(period_start === 1'b0 && sync_level === 3'h2), 1, "second edge after release");
    @(per_done);
    chk(d_plen, 1716, "first period after reset");
    @(per_done);
    chk(d_plen, 1728, "pin adopted after reset");
    chk(n_field, 0, "field start too early");
    $display("reset test done");
    close_out();
  end
endmodule
`default_nettype wire
